// ### rtl/mac_opmode_pkg.sv
// Package: register map, field positions, thresholds and carriers for the operation mode block
package mac_opmode_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_OPERATION_MODE = 4'h0;
  localparam logic [3:0] OFS_PORT_CONFIG    = 4'h4;
  localparam logic [3:0] OFS_PROCESS_STATUS = 4'h8;

  // ---------------------------------------------------------------
  // Operation mode field positions
  // ---------------------------------------------------------------
  localparam int RECEIVE_ALL_BIT      = 30;
  localparam int TX_THRESH_MODE_BIT   = 22;
  localparam int STORE_FORWARD_BIT    = 21;
  localparam int THRESH_CTRL_HI       = 15;
  localparam int THRESH_CTRL_LO       = 14;
  localparam int TX_RUN_COMMAND_BIT   = 13;
  localparam int DUPLEX_SELECT_BIT    = 9;
  localparam int PASS_ALL_MCAST_BIT   = 7;
  localparam int PROMISCUOUS_BIT      = 6;
  // Writable bits and the fixed value seen on all other positions
  localparam logic [31:0] OPMODE_WRITE_MASK  = 32'h4060_E2C0;
  localparam logic [31:0] OPMODE_FIXED_VALUE = 32'h0000_0000;
  localparam logic [31:0] OPMODE_RESET       = 32'h0000_0000;

  // Port configuration and status field positions
  localparam int PORT_SELECT_BIT      = 0;
  localparam int TX_BUF_UNAVAIL_BIT   = 2;
  localparam int TX_STATE_LO          = 20;
  localparam int TX_STATE_HI          = 22;

  // Transmit state codes reported in the status register
  localparam logic [2:0] TX_CODE_STOPPED   = 3'h0;
  localparam logic [2:0] TX_CODE_RUNNING   = 3'h1;
  localparam logic [2:0] TX_CODE_SUSPENDED = 3'h6;

  // ---------------------------------------------------------------
  // Transmit FIFO start thresholds in bytes, indexed {fast, control}
  // ---------------------------------------------------------------
  localparam int FIFO_LEVEL_W = 11;
  localparam logic [FIFO_LEVEL_W-1:0] TX_THRESHOLD [8] = '{
    11'h040, 11'h060, 11'h080, 11'h0A0,
    11'h080, 11'h100, 11'h200, 11'h400
  };

  // Last count of the link clock divider for the slow line rate (divide by 10)
  localparam logic [3:0] SLOW_DIVIDE_LAST = 4'h9;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  typedef struct packed {
    logic valid;       // One-cycle pulse per received frame header
    logic dstMatch;    // Address check passed
    logic dstMulticast;
  } rx_frame_info_t;

  typedef enum logic [3:0] {
    TX_STOPPED   = 4'b0001,
    TX_CHECK     = 4'b0010,
    TX_FETCH     = 4'b0100,
    TX_SUSPENDED = 4'b1000
  } tx_state_t;

endpackage

// ### rtl/mac_operation_mode_control.sv
// Operation mode control: register file, transmit process, rx acceptance, tx start threshold, RMII rate
//
// Contract
// - Receive-all set accepts every incoming frame whatever its destination.
// - Receive-all still runs the address check and reports its outcome in descriptor word0.
// - Threshold mode bit picks 100 Mbps thresholds when 1, 10 Mbps when 0; the code takes the 100 Mbps set whenever port select is 1.
// - In RMII the threshold mode bit picks 25 MHz or 2.5 MHz line clocking.
// - Store-and-forward starts transmission only with a whole packet in the FIFO.
// - Start threshold comes from control bits, threshold mode, store-forward and port select.
// - Run command set while stopped enters running and checks the current descriptor.
// - Device-owned descriptor starts fetching; host-owned descriptor suspends transmit.
// - Clearing run command finishes the current frame before entering stopped.
// - Duplex bit selects half duplex at 0, forced full duplex at 1.
// - Pass-all-multicast accepts every multicast frame regardless of the address check.
// - Promiscuous accepts all frames and skips the address check.
// - Unimplemented mode bits read a fixed value and ignore writes.
// - Suspending on a host-owned descriptor sets buffer-unavailable, cleared by writing one.
`timescale 1ns/1ps
`default_nettype none

module mac_operation_mode_control (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  // Avalon-MM slave
  input  wire mac_opmode_pkg::avs_req_t              avsReq,
  output logic [31:0]                                avsReaddata,
  output logic                                       avsWaitrequest,
  // Transmit descriptor engine
  input  wire logic                                  txDescDone,
  input  wire logic                                  txDescOwned,
  input  wire logic                                  txFrameDone,
  input  wire logic                                  txPollDemand,
  output logic                                       txDescCheck,
  output logic                                       txFetchEnable,
  // Transmit FIFO
  input  wire logic [mac_opmode_pkg::FIFO_LEVEL_W-1:0] txFifoLevel,
  input  wire logic                                  txPacketInFifo,
  output logic                                       txStartOk,
  // Receive address filter
  input  wire mac_opmode_pkg::rx_frame_info_t        rxInfo,
  output logic                                       rxAddrCheckEnable,
  output logic                                       rxAccept,
  output logic                                       rxFilterFail,
  output logic                                       rxResultValid,
  // MAC mode
  output logic                                       fullDuplex,
  // RMII link side
  input  wire logic                                  rmiiRefClk,
  output logic                                       rmiiFast,
  output logic                                       rmiiRateTick
);

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  logic        busAck;
  logic [31:0] operationMode;
  logic        portSelect;
  logic        txBufUnavail;
  mac_opmode_pkg::tx_state_t txState;
  mac_opmode_pkg::tx_state_t next_txState;

  wire         busReq       = avsReq.read | avsReq.write;
  wire         busTake      = busReq & ~busAck;
  wire         writeTake    = avsReq.write & busTake;
  wire         hitOpMode    = avsReq.address == mac_opmode_pkg::OFS_OPERATION_MODE;
  wire         hitPortCfg   = avsReq.address == mac_opmode_pkg::OFS_PORT_CONFIG;
  wire         hitStatus    = avsReq.address == mac_opmode_pkg::OFS_PROCESS_STATUS;
  wire [31:0]  byteMask     = {{8{avsReq.byteenable[3]}}, {8{avsReq.byteenable[2]}},
                               {8{avsReq.byteenable[1]}}, {8{avsReq.byteenable[0]}}};
  // Only implemented positions take write data; the rest hold the fixed value
  wire [31:0]  opWriteMask  = byteMask & mac_opmode_pkg::OPMODE_WRITE_MASK;
  wire [31:0]  next_opMode  = (operationMode & ~opWriteMask) | (avsReq.writedata & opWriteMask);
  wire         opModeWrite  = writeTake & hitOpMode;
  wire         portCfgWrite = writeTake & hitPortCfg & avsReq.byteenable[0];
  wire         statusWrite  = writeTake & hitStatus & avsReq.byteenable[0];

  // Field views of the mode register
  wire         receiveAll       = operationMode[mac_opmode_pkg::RECEIVE_ALL_BIT];
  wire         txThresholdMode  = operationMode[mac_opmode_pkg::TX_THRESH_MODE_BIT];
  wire         storeForward     = operationMode[mac_opmode_pkg::STORE_FORWARD_BIT];
  wire [1:0]   thresholdControl = operationMode[mac_opmode_pkg::THRESH_CTRL_HI:mac_opmode_pkg::THRESH_CTRL_LO];
  wire         txRunCommand     = operationMode[mac_opmode_pkg::TX_RUN_COMMAND_BIT];
  wire         duplexSelect     = operationMode[mac_opmode_pkg::DUPLEX_SELECT_BIT];
  wire         passAllMulticast = operationMode[mac_opmode_pkg::PASS_ALL_MCAST_BIT];
  wire         promiscuous      = operationMode[mac_opmode_pkg::PROMISCUOUS_BIT];

  // Status word: transmit state code and the sticky buffer-unavailable flag
  wire [2:0]   txStateCode = (txState == mac_opmode_pkg::TX_STOPPED)   ? mac_opmode_pkg::TX_CODE_STOPPED :
                             (txState == mac_opmode_pkg::TX_SUSPENDED) ? mac_opmode_pkg::TX_CODE_SUSPENDED :
                                                                         mac_opmode_pkg::TX_CODE_RUNNING;
  logic [31:0] statusWord;
  logic [31:0] portCfgWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[mac_opmode_pkg::TX_BUF_UNAVAIL_BIT] = txBufUnavail;
    statusWord[mac_opmode_pkg::TX_STATE_HI:mac_opmode_pkg::TX_STATE_LO] = txStateCode;
    portCfgWord = 32'h0000_0000;
    portCfgWord[mac_opmode_pkg::PORT_SELECT_BIT] = portSelect;
  end

  // Unimplemented positions read back the fixed value
  wire [31:0]  opModeRead = (operationMode & mac_opmode_pkg::OPMODE_WRITE_MASK) |
                            (mac_opmode_pkg::OPMODE_FIXED_VALUE & ~mac_opmode_pkg::OPMODE_WRITE_MASK);
  wire [31:0]  readMux    = hitOpMode  ? opModeRead :
                            hitPortCfg ? portCfgWord :
                            hitStatus  ? statusWord : 32'h0000_0000;

  // One wait state per access keeps read data registered
  assign avsWaitrequest = busReq & ~busAck;

  // ---------------------------------------------------------------
  // Bus acknowledge and read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busAck      <= 1'b0;
      avsReaddata <= 32'h0000_0000;
    end else begin
      busAck <= busTake;
      if (busTake && avsReq.read) begin
        avsReaddata <= readMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Mode bits are stored as written; software keeps them steady while running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operationMode <= mac_opmode_pkg::OPMODE_RESET;
      portSelect    <= 1'b0;
    end else begin
      if (opModeWrite) begin
        operationMode <= next_opMode;
      end
      if (portCfgWrite) begin
        portSelect <= avsReq.writedata[mac_opmode_pkg::PORT_SELECT_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit process
  // ---------------------------------------------------------------
  always_comb begin
    next_txState = txState;
    case (txState)
      mac_opmode_pkg::TX_STOPPED: begin
        if (txRunCommand) begin
          next_txState = mac_opmode_pkg::TX_CHECK;
        end
      end
      mac_opmode_pkg::TX_CHECK: begin
        if (!txRunCommand) begin
          next_txState = mac_opmode_pkg::TX_STOPPED;
        end else if (txDescDone) begin
          next_txState = txDescOwned ? mac_opmode_pkg::TX_FETCH : mac_opmode_pkg::TX_SUSPENDED;
        end
      end
      mac_opmode_pkg::TX_FETCH: begin
        // A stop waits for the end of the frame in flight
        if (txFrameDone) begin
          next_txState = txRunCommand ? mac_opmode_pkg::TX_CHECK : mac_opmode_pkg::TX_STOPPED;
        end
      end
      mac_opmode_pkg::TX_SUSPENDED: begin
        if (!txRunCommand) begin
          next_txState = mac_opmode_pkg::TX_STOPPED;
        end else if (txPollDemand) begin
          next_txState = mac_opmode_pkg::TX_CHECK;
        end
      end
      default: begin
        next_txState = mac_opmode_pkg::TX_STOPPED;
      end
    endcase
  end

  // Hardware set wins over a clearing write in the same cycle
  wire suspendEntry   = (txState == mac_opmode_pkg::TX_CHECK) &&
                        (next_txState == mac_opmode_pkg::TX_SUSPENDED);
  wire tuClear        = statusWrite && avsReq.writedata[mac_opmode_pkg::TX_BUF_UNAVAIL_BIT];
  wire next_txBufFlag = suspendEntry | (txBufUnavail & ~tuClear);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState      <= mac_opmode_pkg::TX_STOPPED;
      txBufUnavail <= 1'b0;
    end else begin
      txState      <= next_txState;
      txBufUnavail <= next_txBufFlag;
    end
  end

  assign txDescCheck   = txState == mac_opmode_pkg::TX_CHECK;
  assign txFetchEnable = txState == mac_opmode_pkg::TX_FETCH;

  // ---------------------------------------------------------------
  // Transmit start threshold
  // ---------------------------------------------------------------
  // Port select forces the fast table, as that port only runs at the high rate
  wire        fastTable   = txThresholdMode | portSelect;
  wire [2:0]  thrIndex    = {fastTable, thresholdControl};
  wire [mac_opmode_pkg::FIFO_LEVEL_W-1:0] startLevel = mac_opmode_pkg::TX_THRESHOLD[thrIndex];
  wire        levelReached = txFifoLevel >= startLevel;
  // Store-and-forward ignores the level; a short whole packet may always go
  wire        next_startOk = storeForward ? txPacketInFifo : (levelReached | txPacketInFifo);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txStartOk  <= 1'b0;
      fullDuplex <= 1'b0;
    end else begin
      txStartOk  <= next_startOk & txFetchEnable;
      fullDuplex <= duplexSelect;
    end
  end

  // ---------------------------------------------------------------
  // Receive acceptance
  // ---------------------------------------------------------------
  // Address check runs unless promiscuous; receive-all still needs its result
  assign rxAddrCheckEnable = ~promiscuous;
  wire   acceptAny   = promiscuous | receiveAll;
  wire   acceptMcast = passAllMulticast & rxInfo.dstMulticast;
  wire   next_accept = acceptAny | acceptMcast | rxInfo.dstMatch;
  // Promiscuous skips the check, so no failure is ever reported then
  wire   next_fail   = ~promiscuous & ~rxInfo.dstMatch;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxAccept      <= 1'b0;
      rxFilterFail  <= 1'b0;
      rxResultValid <= 1'b0;
    end else begin
      rxResultValid <= rxInfo.valid;
      if (rxInfo.valid) begin
        rxAccept     <= next_accept;
        rxFilterFail <= next_fail;
      end
    end
  end

  // ---------------------------------------------------------------
  // RMII line rate, link clock domain
  // ---------------------------------------------------------------
  // Reset is released synchronously to the link clock
  logic linkRstMeta;
  logic linkRstn;
  always_ff @(posedge rmiiRefClk or negedge rstn) begin
    if (!rstn) begin
      linkRstMeta <= 1'b0;
      linkRstn    <= 1'b0;
    end else begin
      linkRstMeta <= 1'b1;
      linkRstn    <= linkRstMeta;
    end
  end

  // The mode bit is a quasi-static level, so two flops suffice
  logic fastMeta;
  logic [3:0] divCount;
  wire  divWrap       = (divCount == mac_opmode_pkg::SLOW_DIVIDE_LAST);
  wire  [3:0] next_divCount = (rmiiFast || divWrap) ? 4'h0 : divCount + 4'h1;

  always_ff @(posedge rmiiRefClk or negedge linkRstn) begin
    if (!linkRstn) begin
      fastMeta     <= 1'b0;
      rmiiFast     <= 1'b0;
      divCount     <= 4'h0;
      rmiiRateTick <= 1'b0;
    end else begin
      fastMeta     <= txThresholdMode;
      rmiiFast     <= fastMeta;
      divCount     <= next_divCount;
      rmiiRateTick <= rmiiFast | divWrap;
    end
  end

endmodule

`default_nettype wire

// ### bench/mac_opmode_props.sv
// Checker: concurrent properties on the ports of the operation mode block
`timescale 1ns/1ps
`default_nettype none
module mac_opmode_props (
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire mac_opmode_pkg::avs_req_t avsReq,
  input wire logic                     avsWaitrequest,
  input wire logic                     txDescDone,
  input wire logic                     txDescOwned,
  input wire logic                     txFrameDone,
  input wire logic                     txDescCheck,
  input wire logic                     txFetchEnable,
  input wire logic [10:0]              txFifoLevel,
  input wire logic                     txPacketInFifo,
  input wire logic                     txStartOk,
  input wire mac_opmode_pkg::rx_frame_info_t rxInfo,
  input wire logic                     rxAddrCheckEnable,
  input wire logic                     rxAccept,
  input wire logic                     rxFilterFail,
  input wire logic                     rxResultValid,
  input wire logic                     fullDuplex,
  input wire logic                     rmiiRefClk,
  input wire logic                     rmiiFast,
  input wire logic                     rmiiRateTick
);
  // ---------------------------------------------------------------
  // Register shadow
  // ---------------------------------------------------------------
  // Updated at the answer edge, one cycle after the design; the address check enable and duplex checks skip that cycle
  wire        wrAns = avsReq.write && !avsWaitrequest;
  wire [31:0] lane  = {{8{avsReq.byteenable[3]}}, {8{avsReq.byteenable[2]}},
                       {8{avsReq.byteenable[1]}}, {8{avsReq.byteenable[0]}}};
  wire [31:0] wmask = lane & mac_opmode_pkg::OPMODE_WRITE_MASK;
  logic [31:0] om;
  logic        ps;
  wire [10:0] th    = mac_opmode_pkg::TX_THRESHOLD[{om[22] | ps, om[15:14]}];
  wire        lvlOk = txFifoLevel >= th;
  // Shadow of operation_mode and port_select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      om <= 32'h0000_0000;
      ps <= 1'b0;
    end else if (wrAns && avsReq.address == mac_opmode_pkg::OFS_OPERATION_MODE) begin
      om <= (om & ~wmask) | (avsReq.writedata & wmask);
    end else if (wrAns && avsReq.address == mac_opmode_pkg::OFS_PORT_CONFIG && avsReq.byteenable[0]) begin
      ps <= avsReq.writedata[0];
    end
  end
  property p_rx_fail;
    @(posedge clk) disable iff (!rstn) rxInfo.valid |=> rxResultValid && rxFilterFail == $past(!om[6] && !rxInfo.dstMatch);
  endproperty
  a_rx_fail: assert property (p_rx_fail) else $error("filter result wrong");
  property p_rx_acc;
    @(posedge clk) disable iff (!rstn)
      rxInfo.valid |=> rxAccept == $past(om[30] | om[6] | (om[7] & rxInfo.dstMulticast) | rxInfo.dstMatch);
  endproperty
  a_rx_acc: assert property (p_rx_acc) else $error("accept wrong");
  property p_rx_pr;
    @(posedge clk) disable iff (!rstn) !wrAns |-> rxAddrCheckEnable == !om[6];
  endproperty
  a_rx_pr: assert property (p_rx_pr) else $error("address check enable wrong");
  property p_fd;
    @(posedge clk) disable iff (!rstn) !wrAns && !$past(wrAns) |-> fullDuplex == om[9];
  endproperty
  a_fd: assert property (p_fd) else $error("duplex wrong");
  property p_fetch;
    @(posedge clk) disable iff (!rstn) txDescCheck && txDescDone && txDescOwned |=> txFetchEnable;
  endproperty
  a_fetch: assert property (p_fetch) else $error("owned descriptor not fetched");
  property p_hold;
    @(posedge clk) disable iff (!rstn) txFetchEnable && !txFrameDone |=> txFetchEnable;
  endproperty
  a_hold: assert property (p_hold) else $error("frame cut short");
  property p_th;
    @(posedge clk) disable iff (!rstn)
      txFetchEnable |=> txStartOk == $past(om[21] ? txPacketInFifo : lvlOk || txPacketInFifo);
  endproperty
  a_th: assert property (p_th) else $error("start threshold wrong");
  property p_fast;
    @(posedge rmiiRefClk) disable iff (!rstn) rmiiFast && $past(rmiiFast) |-> rmiiRateTick;
  endproperty
  a_fast: assert property (p_fast) else $error("fast rate tick missing");
endmodule
`default_nettype wire

// ### bench/mac_opmode_partner.sv
// Partner model: transmit descriptor list and FIFO fill beyond the transmit process
`timescale 1ns/1ps
`default_nettype none
module mac_opmode_partner (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        txDescCheck,
  input  wire logic        txFetchEnable,
  input  wire logic        descOwned,
  input  wire logic [3:0]  descWait,
  input  wire logic [10:0] pktLen,
  output logic             txDescDone,
  output logic             txDescOwned,
  output logic [10:0]      txFifoLevel,
  output logic             txPacketInFifo,
  output logic             txFrameDone
);
  logic [3:0] cnt;
  // Ownership only means something with the done pulse, so show the inverse otherwise
  assign txDescOwned    = txDescDone ? descOwned : !descOwned;
  assign txPacketInFifo = txFifoLevel >= pktLen;
  // Answer a check after descWait cycles; fill 16 bytes a cycle while fetching
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt         <= 4'h0;
      txDescDone  <= 1'b0;
      txFifoLevel <= 11'h000;
      txFrameDone <= 1'b0;
    end else begin
      txDescDone  <= txDescCheck && !txDescDone && cnt == descWait;
      cnt         <= (txDescCheck && cnt != descWait) ? cnt + 4'h1 : 4'h0;
      txFifoLevel <= !txFetchEnable ? 11'h000 : (txFifoLevel == 11'h7F0) ? txFifoLevel : txFifoLevel + 11'h010;
      txFrameDone <= txFetchEnable && txFifoLevel == 11'h7E0;
    end
  end
endmodule
`default_nettype wire

// ### bench/mac_operation_mode_control_test.sv
// Testbench: self-checking bench for the operation mode block
`timescale 1ns/1ps
`default_nettype none
module mac_operation_mode_control_test;
  localparam logic [3:0] OM = mac_opmode_pkg::OFS_OPERATION_MODE;
  localparam logic [3:0] ST = mac_opmode_pkg::OFS_PROCESS_STATUS;
  mac_opmode_pkg::avs_req_t       avsReq;
  mac_opmode_pkg::rx_frame_info_t rxInfo;
  logic [31:0] avsReaddata, q;
  logic [10:0] txFifoLevel, pktLen;
  logic [3:0]  descWait;
  logic        clk, rstn, rmiiRefClk, avsWaitrequest, txDescDone, txDescOwned, txFrameDone, descOwned;
  logic        txDescCheck, txFetchEnable, txPacketInFifo, txStartOk, rxAddrCheckEnable, rxAccept;
  logic        rxFilterFail, rxResultValid, fullDuplex, rmiiFast, rmiiRateTick;
  int          n_mismatch, n_tests, cyc;
  mac_operation_mode_control u_dut (.clk(clk), .rstn(rstn), .avsReq(avsReq), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .txDescDone(txDescDone), .txDescOwned(txDescOwned),
    .txFrameDone(txFrameDone), .txPollDemand(1'b0), .txDescCheck(txDescCheck), .txFetchEnable(txFetchEnable),
    .txFifoLevel(txFifoLevel), .txPacketInFifo(txPacketInFifo), .txStartOk(txStartOk), .rxInfo(rxInfo),
    .rxAddrCheckEnable(rxAddrCheckEnable), .rxAccept(rxAccept), .rxFilterFail(rxFilterFail),
    .rxResultValid(rxResultValid), .fullDuplex(fullDuplex), .rmiiRefClk(rmiiRefClk), .rmiiFast(rmiiFast),
    .rmiiRateTick(rmiiRateTick));
  mac_opmode_partner u_partner (.clk(clk), .rstn(rstn), .txDescCheck(txDescCheck), .txFetchEnable(txFetchEnable),
    .descOwned(descOwned), .descWait(descWait), .pktLen(pktLen), .txDescDone(txDescDone),
    .txDescOwned(txDescOwned), .txFifoLevel(txFifoLevel), .txPacketInFifo(txPacketInFifo),
    .txFrameDone(txFrameDone));
  // System clock, and a link clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rmiiRefClk = 1'b0;
    #7;
    forever #40 rmiiRefClk = ~rmiiRefClk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Bus cycle held until the rising edge that samples waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avsReq <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsReq <= '0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset values, fixed bits, unmapped space, suspend on a host-owned descriptor
  task automatic reg_access;
    bus(1'b0, OM, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b1, OM, 32'hFFFF_FFFF);
    bus(1'b0, OM, 32'h0);
    chk(q, mac_opmode_pkg::OPMODE_WRITE_MASK);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b0, ST, 32'h0);
    chk(q[22:20], mac_opmode_pkg::TX_CODE_SUSPENDED);
    chk(q[2], 1'b1);
    bus(1'b1, ST, 32'h0000_0004);
    bus(1'b0, ST, 32'h0);
    chk(q[2], 1'b0);
    bus(1'b1, OM, 32'h0);
    bus(1'b0, ST, 32'h0);
    chk(q[22:20], mac_opmode_pkg::TX_CODE_STOPPED);
  endtask
  // Every threshold setting, port select, then store-and-forward; stop in mid-frame
  task automatic tx_thresh;
    logic [31:0] m;
    logic [10:0] th;
    descOwned <= 1'b1;
    descWait  <= 4'h3;
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, mac_opmode_pkg::OFS_PORT_CONFIG, {31'h0, i == 8});
      pktLen <= (i == 9) ? 11'h300 : 11'h7F0;
      m  = {9'h000, i[2], i == 9, 5'h00, i[1:0], 1'b1, 13'h0000};
      th = (i == 9) ? 11'h300 : mac_opmode_pkg::TX_THRESHOLD[(i == 8) ? 4 : i[2:0]];
      bus(1'b1, OM, m);
      do @(negedge clk); while (txStartOk !== 1'b1);
      chk(txFifoLevel, th + 11'h010);
      bus(1'b1, OM, m & 32'hFFFF_DFFF);
      chk(txFetchEnable, 1'b1);
      do @(negedge clk); while (txFetchEnable !== 1'b0 || txDescCheck !== 1'b0);
      bus(1'b0, ST, 32'h0);
      chk(q[22:20], mac_opmode_pkg::TX_CODE_STOPPED);
    end
  endtask
  // All combinations of promiscuous, receive-all, multicast pass, match and multicast
  task automatic rx_filter;
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      bus(1'b1, OM, {1'b0, v[3], 22'h000000, v[2], v[4], 6'h00});
      @(posedge clk);
      rxInfo <= '{valid: 1'b1, dstMatch: v[1], dstMulticast: v[0]};
      @(posedge clk);
      rxInfo <= '0;
      @(negedge clk);
      chk(rxResultValid, 1'b1);
      chk(rxAccept, v[4] | v[3] | (v[2] & v[0]) | v[1]);
      chk(rxFilterFail, !v[4] && !v[1]);
      chk(rxAddrCheckEnable, !v[4]);
    end
  endtask
  // Duplex copy and link rate, set while the transmit process is stopped
  task automatic mode_link(input logic fast);
    int n;
    bus(1'b1, OM, {9'h000, fast, 12'h000, fast, 9'h000});
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(fullDuplex, fast);
    repeat (4) @(negedge rmiiRefClk);
    n = 0;
    repeat (20) begin
      @(negedge rmiiRefClk);
      n += rmiiRateTick;
    end
    chk(rmiiFast, fast);
    chk(n, fast ? 20 : 2);
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0;
    avsReq = '0;
    rxInfo = '0;
    descOwned = 1'b0;
    descWait = 4'h0;
    pktLen = 11'h7F0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    reg_access();
    tx_thresh();
    rx_filter();
    mode_link(1'b1);
    mode_link(1'b0);
    wrap_up();
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
endmodule
bind mac_operation_mode_control mac_opmode_props u_props (.clk(clk), .rstn(rstn), .avsReq(avsReq),
  .avsWaitrequest(avsWaitrequest), .txDescDone(txDescDone), .txDescOwned(txDescOwned), .txFrameDone(txFrameDone),
  .txDescCheck(txDescCheck), .txFetchEnable(txFetchEnable), .txFifoLevel(txFifoLevel),
  .txPacketInFifo(txPacketInFifo), .txStartOk(txStartOk), .rxInfo(rxInfo), .rxAddrCheckEnable(rxAddrCheckEnable),
  .rxAccept(rxAccept), .rxFilterFail(rxFilterFail), .rxResultValid(rxResultValid), .fullDuplex(fullDuplex),
  .rmiiRefClk(rmiiRefClk), .rmiiFast(rmiiFast), .rmiiRateTick(rmiiRateTick));
`default_nettype wire
